// file: sensor_port_pkg.sv
/*
 * Shared constants, carrier structs and state encodings of the sensor serial output port.
 * Assumes a 125 MHz core clock and a far-end bus master clocking the shared serial pins.
 */
package sensor_port_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int I2C_MAX_KHZ = 400;
	localparam int SPI_MAX_KHZ = 800;
	// core cycles in half a link period; edge detection via synchronisers needs this well above 3
	localparam int I2C_HALF_CYCLES = 1000000 / (2 * I2C_MAX_KHZ * CLK_PERIOD_NS);
	localparam int SPI_HALF_CYCLES = 1000000 / (2 * SPI_MAX_KHZ * CLK_PERIOD_NS);

	// ==========================================================
	// output selection and addressing
	localparam logic [2:0] SEL_TWO_WIRE = 3'h1;
	localparam logic [2:0] SEL_SPI = 3'h3;
	localparam logic [2:0] SEL_PDM_CAP = 3'h4;
	localparam logic [2:0] SEL_PDM_CAP_TEMP = 3'h6;
	localparam logic [2:0] LOCK_ON = 3'h3;
	localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h28;
	localparam logic [2:0] DEFAULT_LOCK = LOCK_ON;
	localparam logic [2:0] DEFAULT_SEL = SEL_TWO_WIRE;
	localparam logic DEFAULT_SPI_PHASE = 1'h0;

	// ==========================================================
	// configuration memory and field positions
	localparam int CFG_WORDS = 32;
	localparam int CFG_DATA_W = 16;
	localparam int CFG_PAR_W = 6;
	localparam int CFG_CODE_W = CFG_DATA_W + CFG_PAR_W;
	localparam int CFG_ADDR_W = 5;
	localparam logic [4:0] CFG_ADDR_CUST = 5'h02;
	localparam logic [4:0] CFG_ADDR_VENDOR_CONFIG_WORD = 5'h03;
	localparam int VENDOR_SEL_LSB = 0;
	localparam int VENDOR_LOCK_LSB = 3;
	localparam int CUST_ADDR_LSB = 0;
	localparam int CUST_PHASE_BIT = 7;

	// ==========================================================
	// packet layout
	localparam int RESULT_W = 14;
	localparam int PACKET_W = 32;
	localparam logic [13:0] SATURATED = 14'h3fff;
	localparam logic [1:0] ST_FRESH = 2'h0;
	localparam logic [1:0] ST_STALE = 2'h1;
	localparam logic [1:0] ST_CMD = 2'h2;
	localparam logic [1:0] PAD_BITS = 2'h0;
	localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [2:0] PACKET_BYTES = 3'h4;
	localparam logic [5:0] SPI_BIT_LIMIT = 6'h20;
	localparam logic [5:0] SPI_FETCH_BITS = 6'h08;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [2:0] outSel;
		logic [2:0] lockField;
		logic [6:0] slaveAddrField;
		logic spiPhase;
	} cfg_t;

	localparam cfg_t CFG_RESET = '{outSel: DEFAULT_SEL, lockField: DEFAULT_LOCK,
		slaveAddrField: DEFAULT_SLAVE_ADDR, spiPhase: DEFAULT_SPI_PHASE};

	typedef struct packed {
		logic [RESULT_W-1:0] cap;
		logic [RESULT_W-1:0] temp;
	} result_t;

	typedef struct packed {
		logic [CFG_DATA_W-1:0] data;
		logic singleBitCorrect;
		logic doubleBitDetect;
	} ecc_result_t;

	typedef enum logic [2:0] {
		I2C_IDLE = 3'b000,
		I2C_ADDR = 3'b001,
		I2C_TX = 3'b010,
		I2C_RX = 3'b011,
		I2C_WAIT_STOP = 3'b100
	} i2c_state_t;

endpackage : sensor_port_pkg

// file: sync_two_ff.sv
/*
 * Two-flop level synchroniser, parameterised width and reset value.
 * Assumes each bit is an independent level; multi-bit words must not pass here.
 */
`timescale 1ns/1ns
module sync_two_ff #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	// ==========================================================
	// first stage is read only by the second
	always_comb begin
		next_st.meta = d;
		next_st.stable = st.meta;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= {INIT, INIT};
		end else begin
			st <= next_st;
		end
	end

	assign q = st.stable;

endmodule : sync_two_ff

// file: ecc_word_check.sv
/*
 * Single-correct double-detect check of one 22-bit configuration code word.
 * Assumes Hamming positions 1..21 (checks at powers of two) and overall parity in bit 0.
 */
`timescale 1ns/1ns
module ecc_word_check
	import sensor_port_pkg::*;
(
	input wire logic [CFG_CODE_W-1:0] code,
	output ecc_result_t res
);
	logic [4:0] syndrome;
	logic parity;
	logic [CFG_CODE_W-1:0] fixed;
	logic [4:0] k;

	// ==========================================================
	// syndrome, correction, extraction
	always_comb begin
		syndrome = '0;
		k = '0;
		parity = ^code;
		for (int i = 1; i < CFG_CODE_W; i++) begin
			if (code[i]) begin
				syndrome = syndrome ^ 5'(i);
			end
		end
		fixed = code;
		// a double error leaves the word untouched: software sees it raw
		if (parity && syndrome != 5'h00 && syndrome < 5'(CFG_CODE_W)) begin
			fixed[syndrome] = ~code[syndrome];
		end
		res.singleBitCorrect = parity && syndrome < 5'(CFG_CODE_W);
		res.doubleBitDetect = (!parity && syndrome != 5'h00) || (parity && syndrome >= 5'(CFG_CODE_W));
		res.data = '0;
		for (int i = 1; i < CFG_CODE_W; i++) begin
			if ((i & (i - 1)) != 0) begin
				res.data[k[3:0]] = fixed[i];
				k = k + 5'h01;
			end
		end
	end

endmodule : ecc_word_check

// file: sensor_serial_output_port.sv
/*
 * Serial result-output port: two-wire slave, read-only SPI, shared-pin muxing, status packet.
 * Assumes a measurement core that supplies 14-bit results, density streams and alarms on clk.
 */
`timescale 1ns/1ns
module sensor_serial_output_port (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic linkClk,
	input wire logic clkPinIn,
	input wire logic dataPinIn,
	output logic dataPinOut,
	output logic dataPinOe,
	input wire logic selectPinN,
	output logic readyPinOut,
	output logic alarmLowPinOut,
	output logic alarmHighPinOut,
	input wire logic capDensityOut,
	input wire logic tempDensityOut,
	input wire logic alarmHighIn,
	input wire logic alarmLowIn,
	input wire logic resultValid,
	input wire sensor_port_pkg::result_t result,
	input wire logic diagFault,
	input wire logic commandMode,
	input wire logic sleepMode,
	input wire logic cfgReadValid,
	input wire logic [sensor_port_pkg::CFG_ADDR_W-1:0] cfgReadAddr,
	input wire logic [sensor_port_pkg::CFG_CODE_W-1:0] cfgReadCode,
	output logic [sensor_port_pkg::CFG_DATA_W-1:0] cfgReadData,
	output logic singleBitCorrect,
	output logic doubleBitDetect,
	output logic eccDiag,
	output logic measureRequestCmd,
	output logic resultFetchCmd,
	output logic calValid,
	output logic [7:0] calByte,
	output sensor_port_pkg::cfg_t activeCfg
);
	import sensor_port_pkg::*;

	typedef struct packed {
		logic sclPrev;
		logic sdaPrev;
		logic ssPrev;
		cfg_t cfg;
		result_t outRes;
		logic fetched;
		logic ready;
		logic eccDiag;
		logic secFlag;
		logic dedFlag;
		logic [CFG_DATA_W-1:0] cfgData;
		logic measReq;
		logic fetchPulse;
		logic calValid;
		logic [7:0] calByte;
		logic [7:0] shiftIn;
		i2c_state_t i2cState;
		logic [3:0] bitCnt;
		logic [2:0] byteIdx;
		logic isRead;
		logic addrHit;
		logic fetchArmed;
		logic measArmed;
		logic [PACKET_W-1:0] packet;
		logic [PACKET_W-1:0] spiPacket;
		logic spiSawBits;
		logic dataOe;
		logic pin8;
		logic pin9;
		logic pin10;
	} core_t;

	core_t core;
	core_t next_core;
	ecc_result_t eccRes;
	logic [3:0] syncd;
	logic sclS, sdaS, ssS, wordS;
	logic [5:0] cntRise, cntFall, driveCnt, sampleCnt;
	logic misoBit, wordBits;
	logic twoWire, spiMode;
	logic startCond, stopCond, sclRise, sclFall;
	logic fetchEvt, mrEvt, mrClr, loadI2c, addrDecide;
	logic [PACKET_W-1:0] pkt;

	// ==========================================================
	// packet assembly
	function automatic logic [PACKET_W-1:0] buildPacket(result_t r, logic fetched, logic cmd,
		logic diag);
		logic [1:0] status;
		result_t v;
		status = cmd ? ST_CMD : (fetched ? ST_STALE : ST_FRESH);
		v = diag ? result_t'{cap: SATURATED, temp: SATURATED} : r;
		// results are already 14 bits wide; MSB leaves first
		return {status, v.cap, v.temp, PAD_BITS};
	endfunction : buildPacket

	ecc_word_check u_ecc (
		.code(cfgReadCode),
		.res(eccRes)
	);

	// ==========================================================
	// link clock domain: SPI bit position, cleared while select is high
	// the phase bit is quasi-static configuration and is not resynchronised
	always_ff @(posedge linkClk or posedge selectPinN) begin
		if (selectPinN) begin
			cntRise <= '0;
		end else if (cntRise != SPI_BIT_LIMIT) begin
			cntRise <= cntRise + 6'h01;
		end
	end

	always_ff @(negedge linkClk or posedge selectPinN) begin
		if (selectPinN) begin
			cntFall <= '0;
		end else if (cntFall != SPI_BIT_LIMIT) begin
			cntFall <= cntFall + 6'h01;
		end
	end

	assign driveCnt = core.cfg.spiPhase ? cntRise : cntFall;
	assign sampleCnt = core.cfg.spiPhase ? cntFall : cntRise;
	// the packet word holds still for the whole frame, so indexing across domains is safe
	assign misoBit = (driveCnt < SPI_BIT_LIMIT) && core.spiPacket[~driveCnt[4:0]];
	assign wordBits = sampleCnt >= SPI_FETCH_BITS;

	// ==========================================================
	// pins into the core domain; rates far below clk keep edge detection reliable
	sync_two_ff #(.W(4), .INIT(4'he)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d({clkPinIn, dataPinIn, selectPinN, wordBits}),
		.q(syncd)
	);

	assign {sclS, sdaS, ssS, wordS} = syncd;
	assign twoWire = core.cfg.outSel != SEL_SPI;
	assign spiMode = core.cfg.outSel == SEL_SPI;
	assign startCond = twoWire && sclS && core.sdaPrev && !sdaS;
	assign stopCond = twoWire && sclS && !core.sdaPrev && sdaS;
	assign sclRise = sclS && !core.sclPrev;
	assign sclFall = !sclS && core.sclPrev;
	assign pkt = buildPacket(core.outRes, core.fetched, commandMode, diagFault || core.eccDiag);

	// ==========================================================
	// core next state
	always_comb begin
		next_core = core;
		next_core.sclPrev = sclS;
		next_core.sdaPrev = sdaS;
		next_core.ssPrev = ssS;
		next_core.measReq = 1'b0;
		next_core.fetchPulse = 1'b0;
		next_core.calValid = 1'b0;
		fetchEvt = 1'b0;
		mrEvt = 1'b0;
		loadI2c = 1'b0;
		addrDecide = 1'b0;
		// configuration word checking
		if (cfgReadValid) begin
			next_core.cfgData = eccRes.data;
			if (commandMode) begin
				next_core.secFlag = eccRes.singleBitCorrect && !eccRes.doubleBitDetect;
				next_core.dedFlag = eccRes.doubleBitDetect;
			end else if (eccRes.doubleBitDetect) begin
				next_core.eccDiag = 1'b1;
			end
			if (!eccRes.doubleBitDetect && cfgReadAddr == CFG_ADDR_VENDOR_CONFIG_WORD) begin
				next_core.cfg.outSel = eccRes.data[VENDOR_SEL_LSB +: 3];
				next_core.cfg.lockField = eccRes.data[VENDOR_LOCK_LSB +: 3];
			end
			if (!eccRes.doubleBitDetect && cfgReadAddr == CFG_ADDR_CUST) begin
				next_core.cfg.slaveAddrField = eccRes.data[CUST_ADDR_LSB +: 7];
				next_core.cfg.spiPhase = eccRes.data[CUST_PHASE_BIT];
			end
		end
		// two-wire slave; start or stop ends any transfer in progress
		if (startCond || stopCond) begin
			fetchEvt = core.fetchArmed;
			mrEvt = core.measArmed;
			next_core.fetchArmed = 1'b0;
			next_core.measArmed = 1'b0;
			next_core.bitCnt = '0;
			next_core.byteIdx = '0;
			next_core.i2cState = startCond ? I2C_ADDR : I2C_IDLE;
		end else begin
			case (core.i2cState)
				I2C_ADDR: begin
					if (sclRise && core.bitCnt == ACK_BIT) begin
						next_core.bitCnt = '0;
						if (!core.addrHit) begin
							next_core.i2cState = I2C_WAIT_STOP;
						end else if (core.isRead) begin
							next_core.i2cState = I2C_TX;
							next_core.fetchArmed = 1'b1;
						end else begin
							next_core.i2cState = I2C_RX;
							next_core.measArmed = 1'b1;
						end
					end else if (sclRise) begin
						next_core.shiftIn = {core.shiftIn[6:0], sdaS};
						next_core.bitCnt = core.bitCnt + 4'h1;
						if (core.bitCnt == ADDR_LAST_BIT) begin
							addrDecide = 1'b1;
							next_core.isRead = sdaS;
							next_core.addrHit = (core.cfg.lockField != LOCK_ON)
								|| (core.shiftIn[6:0] == core.cfg.slaveAddrField);
							loadI2c = sdaS && next_core.addrHit;
						end
					end
					if (sclFall) begin
						next_core.dataOe = (core.bitCnt == ACK_BIT) && core.addrHit;
					end
					if (loadI2c) begin
						next_core.packet = pkt;
					end
				end
				I2C_TX: begin
					// past the fourth byte the line is released, so the master reads ones
					if (sclFall) begin
						next_core.dataOe = (core.bitCnt != ACK_BIT) && (core.byteIdx < PACKET_BYTES)
							&& !core.packet[~{core.byteIdx[1:0], core.bitCnt[2:0]}];
					end
					if (sclRise && core.bitCnt == ACK_BIT) begin
						next_core.bitCnt = '0;
						if (sdaS) begin
							next_core.i2cState = I2C_WAIT_STOP;
						end else if (core.byteIdx != PACKET_BYTES) begin
							next_core.byteIdx = core.byteIdx + 3'h1;
						end
					end else if (sclRise) begin
						next_core.bitCnt = core.bitCnt + 4'h1;
					end
				end
				I2C_RX: begin
					if (sclFall) begin
						next_core.dataOe = core.bitCnt == ACK_BIT;
					end
					if (sclRise && core.bitCnt == ACK_BIT) begin
						next_core.bitCnt = '0;
						next_core.calValid = commandMode;
						next_core.calByte = core.shiftIn;
					end else if (sclRise) begin
						next_core.shiftIn = {core.shiftIn[6:0], sdaS};
						next_core.bitCnt = core.bitCnt + 4'h1;
					end
				end
				I2C_IDLE, I2C_WAIT_STOP: begin
					next_core.dataOe = 1'b0;
				end
				default: begin
					next_core.i2cState = I2C_IDLE;
				end
			endcase
		end
		if (!twoWire) begin
			next_core.i2cState = I2C_IDLE;
		end
		// SPI frame: snapshot at select fall, events at select rise
		if (spiMode && core.ssPrev && !ssS) begin
			next_core.spiPacket = pkt;
			next_core.spiSawBits = 1'b0;
		end else if (!ssS && wordS) begin
			next_core.spiSawBits = 1'b1;
		end
		if (spiMode && !core.ssPrev && ssS && core.spiSawBits) begin
			fetchEvt = 1'b1;
			mrEvt = 1'b1;
		end
		// result register, status and ready; a new result wins over a fetch
		mrClr = mrEvt && sleepMode && !commandMode;
		next_core.measReq = mrClr;
		next_core.fetchPulse = fetchEvt;
		if (resultValid) begin
			next_core.outRes = result;
		end
		next_core.fetched = !resultValid && (fetchEvt || core.fetched);
		next_core.ready = resultValid || (!(fetchEvt || mrClr) && core.ready);
		// shared pins
		next_core.pin10 = (core.cfg.outSel == SEL_PDM_CAP || core.cfg.outSel == SEL_PDM_CAP_TEMP)
			? capDensityOut : core.ready;
		next_core.pin8 = (core.cfg.outSel == SEL_PDM_CAP_TEMP) ? tempDensityOut : alarmLowIn;
		next_core.pin9 = alarmHighIn;
		if (spiMode) begin
			next_core.dataOe = !ssS;
		end else if (!twoWire || stopCond || startCond) begin
			next_core.dataOe = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			core <= '0;
			core.cfg <= CFG_RESET;
			core.sclPrev <= 1'b1;
			core.sdaPrev <= 1'b1;
			core.ssPrev <= 1'b1;
		end else begin
			core <= next_core;
		end
	end

	// ==========================================================
	// outputs; MISO follows the link-domain bit index, so that one pin is combinational
	assign dataPinOut = spiMode && misoBit;
	assign dataPinOe = core.dataOe;
	assign readyPinOut = core.pin10;
	assign alarmLowPinOut = core.pin8;
	assign alarmHighPinOut = core.pin9;
	assign cfgReadData = core.cfgData;
	assign singleBitCorrect = core.secFlag;
	assign doubleBitDetect = core.dedFlag;
	assign eccDiag = core.eccDiag;
	assign measureRequestCmd = core.measReq;
	assign resultFetchCmd = core.fetchPulse;
	assign calValid = core.calValid;
	assign calByte = core.calByte;
	assign activeCfg = core.cfg;

	// ==========================================================
	// checks
	chk_ready_on_result: assert property (@(posedge clk) disable iff (sys_rst)
		resultValid |=> core.ready && !core.fetched) else $error("ready not raised by result");
	chk_ready_cleared: assert property (@(posedge clk) disable iff (sys_rst)
		(mrClr || fetchEvt) && !resultValid |=> !core.ready ##1 (!core.ready || $past(resultValid)))
		else $error("ready not cleared");
	chk_status_cmd: assert property (@(posedge clk) disable iff (sys_rst)
		loadI2c && commandMode |=> core.packet[31:30] == ST_CMD) else $error("status not command");
	chk_diag_saturate: assert property (@(posedge clk) disable iff (sys_rst)
		loadI2c && (diagFault || core.eccDiag) |=> core.packet[29:2] == {SATURATED, SATURATED})
		else $error("diagnostic not saturated");
	chk_pad_bits_zero: assert property (@(posedge clk) disable iff (sys_rst)
		spiMode && core.ssPrev && !ssS |=> core.spiPacket[1:0] == PAD_BITS)
		else $error("pad bits not zero");
	chk_alarm_passthru: assert property (@(posedge clk) disable iff (sys_rst)
		!sys_rst |=> core.pin9 == $past(alarmHighIn)) else $error("alarm high altered");
	chk_ded_diag: assert property (@(posedge clk) disable iff (sys_rst)
		cfgReadValid && eccRes.doubleBitDetect && !commandMode |=> core.eccDiag[*2])
		else $error("double error not flagged");
	chk_sec_silent: assert property (@(posedge clk) disable iff (sys_rst)
		cfgReadValid && !eccRes.doubleBitDetect && !core.eccDiag |=> !core.eccDiag)
		else $error("single error raised diagnostic");
	chk_addr_filter: assert property (@(posedge clk) disable iff (sys_rst)
		addrDecide && core.cfg.lockField == LOCK_ON && core.shiftIn[6:0] != core.cfg.slaveAddrField
		|=> !core.addrHit) else $error("foreign address accepted");
	chk_temp_density_pin: assert property (@(posedge clk) disable iff (sys_rst)
		core.cfg.outSel == SEL_PDM_CAP_TEMP && !cfgReadValid |=> core.pin8 == $past(tempDensityOut))
		else $error("temperature density not on pin");
	chk_stale_after_fetch: assert property (@(posedge clk) disable iff (sys_rst)
		fetchEvt && !resultValid |=> core.fetched && resultFetchCmd) else $error("fetch not marked");

endmodule : sensor_serial_output_port

// file: sensor_bus_master.sv
/*
 * Behavioural bus master at the far side of the port: two-wire and read-only SPI transfers.
 * Assumes a pull-up on the data wire; the device pulls it low or drives it while selected.
 */
`timescale 1ns/1ns
module sensor_bus_master (
	output logic scl,
	output logic dataLevel,
	output logic selectN,
	input wire logic dataPinOut,
	input wire logic dataPinOe
);
	// ==========================================================
	// wire and timing
	localparam int HALF_I2C = 1250;
	localparam int HALF_SPI = 40;
	logic sda;
	// released wire floats to the pull-up level, never to the last driven bit
	assign dataLevel = sda & (dataPinOe ? dataPinOut : 1'b1);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		selectN = 1'b1;
	end
	// ==========================================================
	// transfers
	task i2c_bit(input logic b, output logic r);
		sda = b;
		#(HALF_I2C / 2);
		scl = 1'b1;
		#(HALF_I2C / 2);
		r = dataLevel;
		#(HALF_I2C / 2);
		scl = 1'b0;
		#(HALF_I2C / 2);
	endtask : i2c_bit
	task i2c_xfer(input logic [6:0] addr, input logic rd, input int nBytes,
		input logic [7:0] wr, output logic ack, output logic [31:0] got);
		logic r;
		logic [7:0] a;
		a = {addr, rd};
		got = '0;
		sda = 1'b0;
		#HALF_I2C;
		scl = 1'b0;
		#(HALF_I2C / 2);
		for (int i = 7; i >= 0; i--) i2c_bit(a[i], r);
		i2c_bit(1'b1, ack);
		for (int n = 0; n < nBytes && ack === 1'b0; n++) begin
			for (int i = 7; i >= 0; i--) begin
				i2c_bit(rd ? 1'b1 : wr[i], r);
				got = {got[30:0], r};
			end
			i2c_bit(rd ? (n == nBytes - 1) : 1'b1, r);
		end
		sda = 1'b0;
		#(HALF_I2C / 2);
		scl = 1'b1;
		#(HALF_I2C / 2);
		sda = 1'b1;
		#HALF_I2C;
	endtask : i2c_xfer
	task spi_read(input logic phase, input int nBits, output logic [31:0] got);
		got = '0;
		scl = phase;
		#HALF_SPI;
		selectN = 1'b0;
		#2500;
		for (int i = 0; i < nBits; i++) begin
			got = {got[30:0], dataLevel};
			scl = ~scl;
			#HALF_SPI;
			scl = ~scl;
			#HALF_SPI;
		end
		selectN = 1'b1;
		#2000;
		scl = 1'b1;
	endtask : spi_read
endmodule : sensor_bus_master

// file: test_sensor_serial_output_port.sv
/*
 * Self-checking bench of the serial output port: packets, commands, pin muxing, ECC.
 * Assumes the bus master model owns the serial pins; core inputs are driven here.
 */
`timescale 1ns/1ns
module test_sensor_serial_output_port;
	import sensor_port_pkg::*;
	// ==========================================================
	// signals
	logic clk = 1'b0, sys_rst = 1'b1, scl, sda, selN, pinOut, pinOe, rdy, alLo, alHi;
	logic capD = 0, tempD = 0, alHiIn = 0, alLoIn = 0, resultValid = 0, diagFault = 0;
	logic commandMode = 0, sleepMode = 0, cfgValid = 0, sbc, dbd, eccDiag, measReq, fetch, calValid;
	logic [4:0] cfgAddr = '0;
	logic [21:0] cfgCode = '0;
	logic [15:0] cfgData;
	logic [7:0] calByte;
	logic [31:0] got;
	logic ack;
	cfg_t activeCfg;
	result_t result = '0, r1 = '{14'h1234, 14'h2abc}, r2 = '{14'h0c5a, 14'h3e01};
	int fail_count = 0, n_tests = 0, nFetch = 0, nMeas = 0, nCal = 0;
	always #4 clk = ~clk;
	always @(posedge clk) begin
		if (fetch === 1'b1) nFetch++;
		if (measReq === 1'b1) nMeas++;
		if (calValid === 1'b1) nCal++;
	end
	sensor_serial_output_port dut (.clk(clk), .sys_rst(sys_rst), .linkClk(scl), .clkPinIn(scl),
		.dataPinIn(sda), .dataPinOut(pinOut), .dataPinOe(pinOe), .selectPinN(selN),
		.readyPinOut(rdy), .alarmLowPinOut(alLo), .alarmHighPinOut(alHi), .capDensityOut(capD),
		.tempDensityOut(tempD), .alarmHighIn(alHiIn), .alarmLowIn(alLoIn),
		.resultValid(resultValid), .result(result), .diagFault(diagFault),
		.commandMode(commandMode), .sleepMode(sleepMode), .cfgReadValid(cfgValid),
		.cfgReadAddr(cfgAddr), .cfgReadCode(cfgCode), .cfgReadData(cfgData),
		.singleBitCorrect(sbc), .doubleBitDetect(dbd), .eccDiag(eccDiag),
		.measureRequestCmd(measReq), .resultFetchCmd(fetch), .calValid(calValid),
		.calByte(calByte), .activeCfg(activeCfg));
	sensor_bus_master bfm (.scl(scl), .dataLevel(sda), .selectN(selN), .dataPinOut(pinOut),
		.dataPinOe(pinOe));
	// ==========================================================
	// helpers
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task finish_test;
		$display("comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task pulse(input result_t r);
		@(posedge clk);
		result <= r;
		resultValid <= 1'b1;
		@(posedge clk);
		resultValid <= 1'b0;
		tick(3);
	endtask : pulse
	// hamming positions 1..21, checks at powers of two, overall parity in bit 0
	function automatic logic [21:0] enc(input logic [15:0] d);
		logic [21:0] c;
		int k;
		c = '0;
		k = 0;
		for (int p = 3; p < 22; p++) if ((p & (p - 1)) != 0) begin
			c[p] = d[k];
			k++;
		end
		for (int i = 0; i < 5; i++) for (int p = 3; p < 22; p++)
			if (((p >> i) & 1) == 1 && p != (1 << i)) c[1 << i] = c[1 << i] ^ c[p];
		c[0] = ^c[21:1];
		return c;
	endfunction : enc
	task cfg(input logic [4:0] a, input logic [15:0] d, input logic [21:0] flip);
		@(posedge clk);
		cfgAddr <= a;
		cfgCode <= enc(d) ^ flip;
		cfgValid <= 1'b1;
		@(posedge clk);
		cfgValid <= 1'b0;
		tick(3);
	endtask : cfg
	function automatic logic [31:0] pkt(input logic [1:0] st, input result_t r);
		return {st, r.cap, r.temp, 2'h0};
	endfunction : pkt
	// ==========================================================
	// tests
	initial begin
		#700000;
		fail_count++;
		finish_test;
	end
	initial begin
		tick(10);
		sys_rst <= 1'b0;
		tick(4);
		chk(32'(activeCfg), 32'(CFG_RESET));
		pulse(r1);
		chk(32'(rdy), 1);
		bfm.i2c_xfer(7'h28, 1'b1, 4, 8'h0, ack, got);
		chk(got, pkt(ST_FRESH, r1));
		chk(got >> 2, pkt(ST_FRESH, r1) >> 2);
		tick(8);
		chk(nFetch, 1);
		chk(32'(rdy), 0);
		bfm.i2c_xfer(7'h28, 1'b1, 2, 8'h0, ack, got);
		chk(got, pkt(ST_STALE, r1) >> 16);
		bfm.i2c_xfer(7'h29, 1'b1, 1, 8'h0, ack, got);
		chk(32'(ack), 1);
		@(posedge clk);
		sleepMode <= 1'b1;
		pulse(r2);
		bfm.i2c_xfer(7'h28, 1'b0, 0, 8'h0, ack, got);
		tick(8);
		chk(nMeas, 1);
		chk(32'(rdy), 0);
		@(posedge clk);
		sleepMode <= 1'b0;
		diagFault <= 1'b1;
		pulse(r2);
		bfm.i2c_xfer(7'h28, 1'b1, 4, 8'h0, ack, got);
		chk(got, pkt(ST_FRESH, '{14'h3fff, 14'h3fff}));
		@(posedge clk);
		diagFault <= 1'b0;
		commandMode <= 1'b1;
		bfm.i2c_xfer(7'h28, 1'b1, 1, 8'h0, ack, got);
		chk(32'(got[7:6]), 32'(ST_CMD));
		bfm.i2c_xfer(7'h28, 1'b0, 1, 8'ha5, ack, got);
		chk(32'(calByte), 32'h0a5);
		chk(nCal, 1);
		cfg(5'h05, 16'hbeef, 22'h80);
		chk({cfgData, 14'h0, sbc, dbd}, 32'hbeef0002);
		cfg(5'h05, 16'hbeef, 22'h82);
		chk({cfgData, 14'h0, sbc, dbd}, 32'hbee70001);
		@(posedge clk);
		commandMode <= 1'b0;
		cfg(CFG_ADDR_VENDOR_CONFIG_WORD, 16'h0001, '0);
		chk(32'(activeCfg.lockField), 0);
		bfm.i2c_xfer(7'h29, 1'b1, 1, 8'h0, ack, got);
		chk(32'(ack), 0);
		cfg(CFG_ADDR_VENDOR_CONFIG_WORD, 16'h0003, '0);
		pulse(r2);
		bfm.spi_read(1'b0, 32, got);
		chk(got, pkt(ST_FRESH, r2));
		cfg(CFG_ADDR_CUST, 16'h00a8, '0);
		pulse(r1);
		bfm.spi_read(1'b1, 32, got);
		chk(got, pkt(ST_FRESH, r1));
		tick(8);
		chk(nFetch, 7);
		chk(nMeas, 1);
		@(posedge clk);
		sleepMode <= 1'b1;
		bfm.spi_read(1'b1, 8, got);
		chk(got, pkt(ST_STALE, r1) >> 24);
		tick(8);
		chk(nMeas, 2);
		chk(nFetch, 8);
		@(posedge clk);
		sleepMode <= 1'b0;
		diagFault <= 1'b1;
		for (int s = 0; s < 2; s++) for (int v = 0; v < 2; v++) begin
			cfg(CFG_ADDR_VENDOR_CONFIG_WORD, (s == 1) ? 16'h0006 : 16'h0004, '0);
			capD <= v[0];
			tempD <= v[0];
			alHiIn <= v[0];
			tick(4);
			chk(32'(rdy), v);
			chk(32'(alLo), (s == 1) ? v : 0);
			chk(32'(alHi), v);
		end
		cfg(5'h05, 16'hbeef, 22'h80);
		chk(32'(eccDiag), 0);
		cfg(5'h05, 16'hbeef, 22'h82);
		chk(32'(eccDiag), 1);
		finish_test;
	end
endmodule : test_sensor_serial_output_port
